// [design/vec_reloc.sv]
// Purpose : Places the interrupt vector table and reset entry in flash,
//           guards the table select with a timed unlock, and gates
//           interrupts toward the core.
// Assumes : APB slave, zero wait states; fuses and lock bits static.
// Notes   : Global interrupt enable is only read, never written.
//
// Function
// (RULE_01) Select clear: vector table starts at beginning of flash.
// (RULE_02) Select set: table moves to boot section base from size fuses.
// (RULE_03) Software sets change-enable then writes select within four cycles.
// (RULE_04) Change-enable clears four cycles after set, or on select write.
// (RULE_05) Interrupts off from arming until instruction after write is done.
// (RULE_06) No select write: interrupts blocked four cycles, then released.
// (RULE_07) Automatic blocking never alters the global interrupt enable flag.
// (RULE_08) Vectors in boot, application lock set: no interrupts in app code.
// (RULE_09) Vectors in application, boot lock set: no interrupts in boot.
// (RULE_10) 2K boot section with select set: first vector at 0xC01.
// (RULE_11) Boot reset fuse programmed, 2K: reset at 0xC00; vectors 0x001.
// (RULE_12) Reset entry 0x000 if fuse unprogrammed, else boot reset address.
// (RULE_13) Select write without change-enable leaves placement unchanged.
// (RULE_14) After reset select and change-enable both read zero.
//
// The register addresses and the APB slave port were chosen for this implementation.

`timescale 1ns/1ps

module vec_reloc #(
    parameter logic [12:0] BOOT_BASE_1 = 13'h0E00,
    parameter logic [12:0] BOOT_BASE_2 = 13'h0800,
    parameter logic [12:0] BOOT_BASE_3 = 13'h0400
) (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Fuses and lock bits, 0 means programmed for the reset fuse
    input  wire logic        i_boot_reset_fuse,
    input  wire logic [1:0]  i_boot_size_fuses,
    input  wire logic        i_application_lock_bit,
    input  wire logic        i_boot_side_lock_bit,
    // Core side
    input  wire logic        i_exec_in_boot,
    input  wire logic        i_instr_done,
    input  wire logic        i_global_ie,
    input  wire logic        i_irq_req,
    output logic             o_irq_take,
    output logic             o_irq_block,
    output logic [12:0]      o_reset_addr,
    output logic [12:0]      o_vector_base,
    output logic             o_vector_table_select,
    output logic             o_vector_change_enable
);
    // ************************************************************
    // Bus decode
    // ************************************************************
    wire        acc_phase = i_psel && i_penable;
    wire        hit_ctl   = (i_paddr == vec_reloc_pkg::ADDR_MCU_CONTROL);
    wire        hit_stat  = (i_paddr == vec_reloc_pkg::ADDR_STATUS);
    wire        mapped    = hit_ctl || hit_stat;
    wire        ctl_wr    = acc_phase && i_pwrite && hit_ctl;
    wire        wr_ce     = i_pwdata[vec_reloc_pkg::BIT_CHANGE_EN];
    wire        wr_sel    = i_pwdata[vec_reloc_pkg::BIT_SELECT];

    // Zero wait states; unmapped addresses answer with an error
    assign o_pready  = 1'b1;
    assign o_pslverr = acc_phase && !mapped;

    // ************************************************************
    // Control register and unlock sequence
    // ************************************************************
    logic       sel_r;
    logic [5:0] spare_r;
    logic       hold_r;
    logic       ce_active;

    // Arming write: change-enable written as one
    wire arm      = ctl_wr && wr_ce;
    // Committing write: change-enable open and written as zero
    wire commit   = ctl_wr && !wr_ce && ce_active;

    // Window counter; a committing write ends it early
    vec_timer #(
        .W (3)
    ) u_window (
        .i_clk    (i_clk),
        .i_rst_b  (i_rst_b),
        .i_load   (arm),
        .i_value  (vec_reloc_pkg::CHANGE_WINDOW),
        .i_stop   (commit),                             // see (RULE_04)
        .o_active (ce_active),                          // see (RULE_04)
        .o_count  ()
    );

    // Select only moves on a committing write; reset clears it
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sel_r <= vec_reloc_pkg::MCU_CONTROL_RST[1]; // see (RULE_14)
        end else if (commit) begin
            sel_r <= wr_sel;                            // see (RULE_13)
        end
    end

    // Other control bits are plain storage for neighbouring logic
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            spare_r <= vec_reloc_pkg::MCU_CONTROL_RST[7:2];
        end else if (ctl_wr) begin
            spare_r <= i_pwdata[7:2];
        end
    end

    // Block stays after commit until the core retires one more
    // instruction; a fresh arm takes over from the counter
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hold_r <= 1'b0;
        end else if (commit) begin
            hold_r <= 1'b1;                             // see (RULE_05)
        end else if (hold_r && i_instr_done) begin
            hold_r <= 1'b0;
        end
    end

    // ************************************************************
    // Vector and reset placement
    // ************************************************************
    logic [12:0] boot_base;
    always_comb begin
        boot_base = BOOT_BASE_3;
        if (i_boot_size_fuses == vec_reloc_pkg::BOOT_SIZE_2K) begin
            boot_base = vec_reloc_pkg::BOOT_BASE_2K;     // see (RULE_10)
        end else if (i_boot_size_fuses == 2'h1) begin
            boot_base = BOOT_BASE_1;
        end else if (i_boot_size_fuses == 2'h2) begin
            boot_base = BOOT_BASE_2;
        end
    end

    // Table base follows the select; reset entry follows only the reset and size fuses
    wire [12:0] table_start = sel_r ? boot_base               // see (RULE_02)
                                    : vec_reloc_pkg::APP_START; // see (RULE_01)
    assign o_vector_base = table_start + vec_reloc_pkg::VECTOR_OFFSET;
    assign o_reset_addr  = i_boot_reset_fuse
                         ? vec_reloc_pkg::APP_START    // see (RULE_12)
                         : boot_base;                  // see (RULE_11)

    // ************************************************************
    // Interrupt gating
    // ************************************************************
    // Lock suppression depends on where the table is versus where
    // the code runs; a locked section must not jump into the other
    wire lock_app   = sel_r && i_application_lock_bit
                      && !i_exec_in_boot;              // see (RULE_08)
    wire lock_boot  = !sel_r && i_boot_side_lock_bit
                      && i_exec_in_boot;               // see (RULE_09)
    wire lock_block = lock_app || lock_boot;
    // Timed block is a gate only: the enable flag passes untouched
    assign o_irq_block = ce_active || hold_r;          // see (RULE_06)
    assign o_irq_take  = i_irq_req && i_global_ie && !o_irq_block
                       && !lock_block;                 // see (RULE_07)

    assign o_vector_table_select  = sel_r;
    assign o_vector_change_enable = ce_active;

    // ************************************************************
    // Read data
    // ************************************************************
    wire [7:0] ctl_rd  = {spare_r, sel_r, ce_active};
    wire [7:0] stat_rd = {5'h00, i_exec_in_boot, hold_r, o_irq_block};
    wire [31:0] rd_mux = hit_ctl  ? {24'h000000, ctl_rd}
                       : hit_stat ? {24'h000000, stat_rd}
                       : 32'h00000000;

    // Captured in the setup cycle so data is steady during access
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_prdata <= 32'h00000000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= rd_mux;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    // Length of the current change-enable run, for timing checks
    logic [3:0] ce_run;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ce_run <= 4'h0;
        end else if (arm) begin
            ce_run <= 4'h1;
        end else if (ce_active) begin
            ce_run <= ce_run + 4'h1;
        end else begin
            ce_run <= 4'h0;
        end
    end

    property p_base_app;
        @(posedge i_clk) disable iff (!i_rst_b)
        !sel_r |-> o_vector_base == 13'h0001;
    endproperty
    a_base_app: assert property (p_base_app) // see (RULE_01)
        else $error("vector base not at flash start");

    property p_base_boot;
        @(posedge i_clk) disable iff (!i_rst_b)
        sel_r && i_boot_size_fuses == 2'h0 |-> o_vector_base == 13'h0C01;
    endproperty
    a_base_boot: assert property (p_base_boot) // see (RULE_10)
        else $error("boot vector base wrong");

    property p_ce_four;
        @(posedge i_clk) disable iff (!i_rst_b)
        $fell(ce_active) && !$past(ctl_wr) |-> $past(ce_run) == 4'h4;
    endproperty
    a_ce_four: assert property (p_ce_four) // see (RULE_04)
        else $error("change enable not cleared after four cycles");

    property p_ce_commit_clear;
        @(posedge i_clk) disable iff (!i_rst_b)
        commit |=> !ce_active && hold_r;
    endproperty
    a_ce_commit_clear: assert property (p_ce_commit_clear) // see (RULE_04)
        else $error("change enable not cleared by select write");

    // Only three cycles are sure: a commit two edges after the arm,
    // followed by a retire at once, may end the block on the fourth
    property p_block_during;
        @(posedge i_clk) disable iff (!i_rst_b)
        arm |=> o_irq_block throughout (!o_irq_take [*3]);
    endproperty
    a_block_during: assert property (p_block_during) // see (RULE_05)
        else $error("interrupt taken during change window");

    property p_release;
        @(posedge i_clk) disable iff (!i_rst_b)
        $fell(ce_active) && !$past(ctl_wr) && !hold_r |-> !o_irq_block;
    endproperty
    a_release: assert property (p_release) // see (RULE_06)
        else $error("interrupts still blocked after window");

    property p_lock_app;
        @(posedge i_clk) disable iff (!i_rst_b)
        sel_r && i_application_lock_bit && !i_exec_in_boot |-> !o_irq_take;
    endproperty
    a_lock_app: assert property (p_lock_app) // see (RULE_08)
        else $error("interrupt taken in locked application");

    property p_lock_boot;
        @(posedge i_clk) disable iff (!i_rst_b)
        !sel_r && i_boot_side_lock_bit && i_exec_in_boot |-> !o_irq_take;
    endproperty
    a_lock_boot: assert property (p_lock_boot) // see (RULE_09)
        else $error("interrupt taken in locked boot section");

    property p_reset_entry;
        @(posedge i_clk) disable iff (!i_rst_b)
        !i_boot_reset_fuse && i_boot_size_fuses == 2'h0
            |-> o_reset_addr == 13'h0C00;
    endproperty
    a_reset_entry: assert property (p_reset_entry) // see (RULE_11)
        else $error("boot reset entry wrong");

    property p_reset_app;
        @(posedge i_clk) disable iff (!i_rst_b)
        i_boot_reset_fuse |-> o_reset_addr == 13'h0000;
    endproperty
    a_reset_app: assert property (p_reset_app) // see (RULE_12)
        else $error("application reset entry wrong");

    property p_locked_sel;
        @(posedge i_clk) disable iff (!i_rst_b)
        ctl_wr && !ce_active |=> sel_r == $past(sel_r);
    endproperty
    a_locked_sel: assert property (p_locked_sel) // see (RULE_13)
        else $error("select changed without unlock");

    c_commit: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        arm ##[2:3] commit);
    c_timeout: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        $fell(ce_active) && !$past(ctl_wr));
    c_hold_end: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        hold_r ##1 !hold_r);
    c_take: cover property (@(posedge i_clk) disable iff (!i_rst_b)
        o_irq_take && sel_r);
endmodule : vec_reloc

// [design/vec_timer.sv]
// Purpose : Shared constants for the vector relocation block and the
//           small countdown used for the change-enable window.
// Assumes : One clock, asynchronous active-low reset.
// Notes   : Package first so that both modules can reference it.

`timescale 1ns/1ps

// ****************************************************************
// Constants
// ****************************************************************
package vec_reloc_pkg;
    // Register map (byte addresses, one 32-bit word each)
    localparam logic [7:0]  ADDR_MCU_CONTROL  = 8'h00;
    localparam logic [7:0]  ADDR_STATUS       = 8'h04;
    // Field positions inside mcu_control
    localparam int          BIT_CHANGE_EN     = 0;
    localparam int          BIT_SELECT        = 1;
    localparam logic [7:0]  MCU_CONTROL_RST   = 8'h00;
    // Field positions inside the status word
    localparam int          BIT_ST_BLOCK      = 0;
    localparam int          BIT_ST_HOLD       = 1;
    localparam int          BIT_ST_IN_BOOT    = 2;
    // Change-enable window length in clock cycles
    localparam logic [2:0]  CHANGE_WINDOW     = 3'h4;
    // Flash word addresses
    localparam int          FLASH_AW          = 13;
    localparam logic [12:0] APP_START         = 13'h0000;
    localparam logic [12:0] VECTOR_OFFSET     = 13'h0001;
    localparam logic [12:0] BOOT_BASE_2K      = 13'h0C00;
    // Boot-size fuse code that selects the 2K section
    localparam logic [1:0]  BOOT_SIZE_2K      = 2'h0;
endpackage : vec_reloc_pkg

// ****************************************************************
// Countdown timer
// ****************************************************************
module vec_timer #(
    parameter int W = 3
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_value,
    input  wire logic         i_stop,
    output logic              o_active,
    output logic [W-1:0]      o_count
);
    logic [W-1:0] count_r;
    logic         active_r;

    // Load wins over stop so a re-arm in the same cycle is honoured
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count_r  <= '0;
            active_r <= 1'b0;
        end else if (i_load) begin
            count_r  <= i_value - W'(1);
            active_r <= 1'b1;
        end else if (i_stop || (active_r && count_r == '0)) begin
            count_r  <= '0;
            active_r <= 1'b0;
        end else if (active_r) begin
            count_r  <= count_r - W'(1);
        end
    end

    assign o_active = active_r;
    assign o_count  = count_r;
endmodule : vec_timer

// [sim/core_model.sv]
// Purpose : Behavioural processor core facing the vector relocation block.
// Assumes : One clock; the core retires an instruction every third cycle.
// Notes   : Latches the vector base at each taken interrupt as its fetch.
`timescale 1ns/1ps

// ****************************************************************
// Core model
// ****************************************************************
module core_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_in_boot,
    input  wire logic        i_ie,
    input  wire logic        i_req,
    input  wire logic        i_irq_take,
    input  wire logic [12:0] i_vector_base,
    output logic             o_exec_in_boot,
    output logic             o_instr_done,
    output logic             o_global_ie,
    output logic             o_irq_req,
    output logic [12:0]      o_fetch_addr
);
    logic [1:0] phase_r;

    // Section, I flag and pending request come from the bench controls
    assign o_exec_in_boot = i_in_boot;
    assign o_global_ie    = i_ie;    // The block only reads this flag
    assign o_irq_req      = i_req;
    assign o_instr_done   = (phase_r == 2'h2);

    // Slow retire rate so the post-commit hold is visible for a while
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phase_r      <= 2'h0;
            o_fetch_addr <= 13'h0000;
        end else begin
            phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
            if (i_irq_take) begin
                o_fetch_addr <= i_vector_base;    // Vector fetch
            end
        end
    end
endmodule : core_model

// [sim/tb_vec_reloc.sv]
// Purpose : Self-checking bench for the vector relocation block.
// Assumes : APB master tasks; core model on the interrupt side.
// Notes   : Boot bases for size codes 1..3 differ from the defaults.
`timescale 1ns/1ps

// ****************************************************************
// Testbench
// ****************************************************************
module tb_vec_reloc;
    localparam logic [12:0] BASES [4] = '{vec_reloc_pkg::BOOT_BASE_2K,
                                          13'h0A00, 13'h0600, 13'h0200};
    logic        i_clk = 1'b0;
    logic        i_rst_b, psel, penable, pwrite, fuse_rst, app_lock;
    logic        boot_lock, in_boot, ie, req, exec_b, done, gie, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, o_prdata;
    logic [1:0]  size;
    logic        o_pready, o_pslverr, o_irq_take, o_irq_block, o_sel, o_ce;
    logic [12:0] o_reset_addr, o_vector_base, fetch;
    int          num_errors = 0;
    int          cmp_count  = 0;

    always #12.5 i_clk = ~i_clk;

    vec_reloc #(.BOOT_BASE_1(BASES[1]), .BOOT_BASE_2(BASES[2]),
                .BOOT_BASE_3(BASES[3])) vec_reloc_i (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_boot_reset_fuse(fuse_rst),
        .i_boot_size_fuses(size), .i_application_lock_bit(app_lock),
        .i_boot_side_lock_bit(boot_lock), .i_exec_in_boot(exec_b),
        .i_instr_done(done), .i_global_ie(gie), .i_irq_req(irq),
        .o_irq_take(o_irq_take), .o_irq_block(o_irq_block),
        .o_reset_addr(o_reset_addr), .o_vector_base(o_vector_base),
        .o_vector_table_select(o_sel), .o_vector_change_enable(o_ce));

    core_model core_model_i (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_in_boot(in_boot), .i_ie(ie),
        .i_req(req), .i_irq_take(o_irq_take),
        .i_vector_base(o_vector_base), .o_exec_in_boot(exec_b),
        .o_instr_done(done), .o_global_ie(gie), .o_irq_req(irq),
        .o_fetch_addr(fetch));

    // Compare and count; four-state equality so X never matches
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge i_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        q = o_prdata;
        e = o_pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
        #1;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input logic exp_err);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0000_0000, q, e);
        check(q, exp);
        check(32'(e), 32'(exp_err));
    endtask : rd

    // Move the core to a section and look at the interrupt gate
    task automatic take_is(input logic ib, input logic exp);
        @(posedge i_clk);
        in_boot <= ib;
        @(posedge i_clk);
        #1;
        check(32'(o_irq_take), 32'(exp));
    endtask : take_is

    // Bounded wait for the automatic block to end
    task automatic wait_unblock();
        for (int k = 0; k < 20 && o_irq_block !== 1'b0; k++) begin
            @(posedge i_clk);
            #1;
        end
        check(32'(o_irq_block), 32'h0);
    endtask : wait_unblock

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // Watchdog well above the fewer than one hundred cycles the tests need
    initial begin
        #(25 * 5000);
        num_errors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        int n_ce;
        int n_blk;
        int n_tk;
        {i_rst_b, psel, penable, pwrite, app_lock, boot_lock, in_boot} = '0;
        {paddr, pwdata, size} = '0;
        {fuse_rst, ie, req} = 3'h7;
        repeat (4) @(posedge i_clk);
        i_rst_b <= 1'b1;
        #1;
        check(32'(o_vector_base), 32'h001);
        check(32'(o_reset_addr), 32'h000);
        rd(8'h00, 32'h0000_0000, 1'b0);
        fuse_rst <= 1'b0;
        @(posedge i_clk);
        #1;
        check(32'(o_reset_addr), 32'hC00);
        check(32'(o_vector_base), 32'h001);
        $display("test reset done");
        // Select write without unlock, status and unmapped reads
        wr(8'h00, 32'h0000_0002);
        check(32'(o_vector_base), 32'h001);
        in_boot <= 1'b1;
        rd(8'h04, 32'h0000_0004, 1'b0);
        in_boot <= 1'b0;
        rd(8'h08, 32'h0000_0000, 1'b1);
        $display("test access done");
        // Unlock left to expire: window and block counted per cycle
        wr(8'h00, 32'h0000_0001);
        {n_ce, n_blk, n_tk} = '0;
        repeat (8) begin
            n_ce  += int'(o_ce === 1'b1);
            n_blk += int'(o_irq_block === 1'b1);
            n_tk  += int'(o_irq_take === 1'b1 && o_ce === 1'b1);
            @(posedge i_clk);
            #1;
        end
        check(32'(n_ce), 32'h4);
        check(32'(n_blk), 32'h4);
        check(32'(n_tk), 32'h0);
        $display("test expiry done");
        // Unlock then commit inside the window
        wr(8'h00, 32'h0000_0001);
        check(32'(o_irq_block), 32'h1);
        wr(8'h00, 32'h0000_0002);
        check(32'(o_ce), 32'h0);
        check(32'(o_vector_base), 32'hC01);
        check(32'(o_irq_block), 32'h1);
        wait_unblock();
        @(posedge i_clk);
        #1;
        check(32'(o_irq_take), 32'h1);
        check(32'(fetch), 32'hC01);
        rd(8'h00, 32'h0000_0002, 1'b0);
        $display("test commit done");
        // Every boot size code, select set, reset fuse programmed
        for (int i = 0; i < 4; i++) begin
            size <= 2'(i);
            @(posedge i_clk);
            #1;
            check(32'(o_vector_base), 32'(BASES[i] + 13'h1));
            check(32'(o_reset_addr), 32'(BASES[i]));
        end
        size <= 2'h0;
        $display("test sizes done");
        // Lock bits against the executing section
        app_lock <= 1'b1;
        take_is(1'b0, 1'b0);
        take_is(1'b1, 1'b1);
        app_lock <= 1'b0;
        wr(8'h00, 32'h0000_0001);
        wr(8'h00, 32'h0000_0000);
        check(32'(o_vector_base), 32'h001);
        wait_unblock();
        boot_lock <= 1'b1;
        take_is(1'b1, 1'b0);
        take_is(1'b0, 1'b1);
        $display("test locks done");
        // Reset in mid-run with select set and the window open
        wr(8'h00, 32'h0000_0001);
        wr(8'h00, 32'h0000_0002);
        check(32'(o_sel), 32'h1);
        wr(8'h00, 32'h0000_0001);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        #1;
        check(32'(o_sel), 32'h0);
        check(32'(o_ce), 32'h0);
        check(32'(o_irq_block), 32'h0);
        check(32'(o_vector_base), 32'h001);
        rd(8'h00, 32'h0000_0000, 1'b0);
        $display("test mid-run reset done");
        report_and_stop();
    end
endmodule : tb_vec_reloc
